// ==== design/lpws_supervisor.sv ====
// Functional notes
// - Transceiver supply on after power-up in debug; software switches it freely.
// - Drive pin or sense pin one high-side on stays on in reset/init/request.
// - Drive pin low-side turns off in reset, resumes in normal state.
// - Sense pin one low-side on stays on in reset, init, normal request.
// - Safe state: bus transceivers off, bus wake-up detection forced enabled.
// - Contact sensing runs in both low-power states.
// - Sensing period selectable from 3 ms to 512 ms.
// - Drive pin pulsed for sense-on time 200/400/800/1600 us, chosen in init.
// - Pulse uses high or low side as held before low-power entry.
// - Sense pins one to three sampled during pulse; any high wakes.
// - Sense level deglitched about 30 us before it counts.
// - Periodic interrupt only in low-power supply-on state, pulse each period.
// - Missing or wrong acknowledge stops interrupts, resets, then normal request.
// - After that failure regulator stays limited in reset, init and normal request until normal mode.
// - Period code 0x0E selects 512 ms.
// - Command 0x1B00 answered with random code in response bits 7..0.
// - Refresh 0x5A plus inverted code; only correct inversion accepted.
// - Acknowledge commands accepted anywhere within the period.
// - No acknowledge needed before the first interrupt pulse.
// - Wake command 0x5C10 leaves periodic interrupts to normal request.
// - Random code changes at every accepted refresh and is always readable.
module lpws_supervisor #(
  parameter int US_DIV = lpws_pkg::US_CYC,
  parameter int DG_CYC = lpws_pkg::DEGLITCH_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire lpws_pkg::lpws_mode_e mode_in,
  input wire logic debug_select_pin_in,
  input wire logic safe_case_b_in,
  input wire logic vcan_set_in,
  input wire logic vcan_clr_in,
  input wire logic aux_cfg_in,
  input wire logic can_cfg_in,
  input wire logic can_wake_cfg_in,
  input wire logic lin_cfg_in,
  input wire logic lin_wake_cfg_in,
  input wire logic io_wake_cfg_in,
  input wire logic io0_hs_cfg_in,
  input wire logic io0_ls_cfg_in,
  input wire logic io1_hs_cfg_in,
  input wire logic io1_ls_cfg_in,
  input wire logic cs_en_in,
  input wire logic [2:0] cs_period_sel_in,
  input wire logic [1:0] sense_on_sel_in,
  input wire logic cint_en_in,
  input wire logic [2:0] sense_pin_in,
  input wire logic spi_valid_in,
  input wire logic [15:0] spi_word_in,
  output logic main_regulator_on_out,
  output logic main_regulator_limited_out,
  output logic vcan_on_out,
  output logic aux_on_out,
  output logic can_on_out,
  output logic can_wake_en_out,
  output logic lin_on_out,
  output logic lin_wake_en_out,
  output logic io_wake_en_out,
  output logic io0_hs_out,
  output logic io0_ls_out,
  output logic io1_hs_out,
  output logic io1_ls_out,
  output logic wake_out,
  output logic int_pulse_out,
  output logic reset_req_out,
  output logic normal_req_out,
  output logic [15:0] spi_resp_out,
  output logic [7:0] random_code_out
);
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_ON} lpws_cs_e;
  typedef enum logic [2:0] {CI_OFF, CI_FIRST, CI_WAIT_RD, CI_WAIT_REF, CI_ACKED, CI_FAIL} lpws_ci_e;

  if (US_DIV < 1 || US_DIV > 65535 || DG_CYC < 1 || DG_CYC > 2047) begin : g_chk
    $error("lpws_supervisor: parameter out of range");
  end

  function automatic logic [18:0] cint_period(input logic [3:0] code);
    cint_period = lpws_pkg::CINT_MAX_US >> (lpws_pkg::CINT_MAX_CODE - code);
  endfunction

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================
  // Synchronisers and microsecond tick
  logic [2:0] sense_meta, sense_sync;
  logic debug_meta, debug_sync;
  logic [15:0] us_cnt, next_us_cnt;
  logic us_tick;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sense_meta <= 3'h0;
      sense_sync <= 3'h0;
      debug_meta <= 1'b0;
      debug_sync <= 1'b0;
    end else begin
      sense_meta <= sense_pin_in;
      sense_sync <= sense_meta;
      debug_meta <= debug_select_pin_in;
      debug_sync <= debug_meta;
    end
  end
  assign us_tick = (us_cnt == 16'(US_DIV - 1));
  always_comb begin
    next_us_cnt = us_tick ? 16'h0000 : us_cnt + 16'h0001;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) us_cnt <= 16'h0000;
    else us_cnt <= next_us_cnt;
  end

  // ==========================================
  // Remembered configuration
  logic [1:0] strap_cnt, next_strap_cnt;
  logic vcan_ctl, next_vcan_ctl;
  logic io0h_mem, io0l_mem, io1h_mem, io1l_mem;
  logic next_io0h_mem, next_io0l_mem, next_io1h_mem, next_io1l_mem;
  logic [1:0] son_sel, next_son_sel;
  always_comb begin
    next_strap_cnt = (strap_cnt == lpws_pkg::STRAP_DONE) ? strap_cnt : strap_cnt + 2'h1;
    next_vcan_ctl = vcan_ctl;
    if (strap_cnt == lpws_pkg::STRAP_LOAD) next_vcan_ctl = debug_sync;
    if (vcan_set_in) next_vcan_ctl = 1'b1;
    if (vcan_clr_in) next_vcan_ctl = 1'b0;
    next_io0h_mem = io0h_mem;
    next_io0l_mem = io0l_mem;
    next_io1h_mem = io1h_mem;
    next_io1l_mem = io1l_mem;
    if (mode_in == lpws_pkg::M_NORMAL) begin
      next_io0h_mem = io0_hs_cfg_in;
      next_io0l_mem = io0_ls_cfg_in;
      next_io1h_mem = io1_hs_cfg_in;
      next_io1l_mem = io1_ls_cfg_in;
    end
    next_son_sel = (mode_in == lpws_pkg::M_INIT) ? sense_on_sel_in : son_sel;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      strap_cnt <= 2'h0;
      vcan_ctl <= 1'b0;
      io0h_mem <= 1'b0;
      io0l_mem <= 1'b0;
      io1h_mem <= 1'b0;
      io1l_mem <= 1'b0;
      son_sel <= 2'h0;
    end else begin
      strap_cnt <= next_strap_cnt;
      vcan_ctl <= next_vcan_ctl;
      io0h_mem <= next_io0h_mem;
      io0l_mem <= next_io0l_mem;
      io1h_mem <= next_io1h_mem;
      io1l_mem <= next_io1l_mem;
      son_sel <= next_son_sel;
    end
  end

  // ==========================================
  // Cyclic sense with deglitch
  lpws_cs_e cs_state, next_cs_state;
  logic [18:0] cs_cnt, next_cs_cnt;
  logic [2:0] dg_hit;
  logic cs_active, next_wake;
  assign cs_active = cs_en_in && (mode_in == lpws_pkg::M_LP_SUPPLY_OFF ||
                                  mode_in == lpws_pkg::M_LP_SUPPLY_ON);
  for (genvar i = 0; i < 3; i++) begin : g_dg
    logic [lpws_pkg::DGW-1:0] cnt, next_cnt;
    always_comb begin
      next_cnt = '0;
      if (cs_state == CS_ON && sense_sync[i]) begin
        next_cnt = (cnt == lpws_pkg::DGW'(DG_CYC)) ? cnt : cnt + 1'b1;
      end
    end
    always_ff @(posedge core_clk_in) begin
      if (rst_in) cnt <= '0;
      else cnt <= next_cnt;
    end
    assign dg_hit[i] = (cnt == lpws_pkg::DGW'(DG_CYC));
  end
  always_comb begin
    next_cs_state = cs_state;
    next_cs_cnt = cs_cnt;
    next_wake = 1'b0;
    case (cs_state)
      CS_IDLE: begin
        if (cs_active) begin
          next_cs_state = CS_WAIT;
          next_cs_cnt = '0;
        end
      end
      CS_WAIT: begin
        if (!cs_active) begin
          next_cs_state = CS_IDLE;
        end else if (us_tick) begin
          if (cs_cnt == lpws_pkg::CS_PERIOD_US[cs_period_sel_in] - 19'h1) begin
            next_cs_state = CS_ON;
            next_cs_cnt = '0;
          end else begin
            next_cs_cnt = cs_cnt + 19'h1;
          end
        end
      end
      CS_ON: begin
        if (!cs_active) begin
          next_cs_state = CS_IDLE;
        end else if (|dg_hit) begin
          next_wake = 1'b1;
          next_cs_state = CS_IDLE;
        end else if (us_tick) begin
          if (cs_cnt == lpws_pkg::SENSE_ON_US[son_sel] - 19'h1) begin
            next_cs_state = CS_WAIT;
            next_cs_cnt = '0;
          end else begin
            next_cs_cnt = cs_cnt + 19'h1;
          end
        end
      end
      default: next_cs_state = CS_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cs_state <= CS_IDLE;
      cs_cnt <= '0;
      wake_out <= 1'b0;
    end else begin
      cs_state <= next_cs_state;
      cs_cnt <= next_cs_cnt;
      wake_out <= next_wake;
    end
  end

  // ==========================================
  // Cyclic interrupt and acknowledge
  lpws_ci_e ci_state, next_ci_state;
  logic [18:0] ci_cnt, next_ci_cnt;
  logic [3:0] cint_code, next_cint_code;
  logic [7:0] lfsr, next_lfsr, next_code;
  logic [15:0] next_resp;
  logic ci_run, is_rd, is_ref, ref_ok, is_wake, is_per, period_end;
  logic cint_fail, next_fail, next_int, next_rst_req, next_nrq;
  assign ci_run = cint_en_in && mode_in == lpws_pkg::M_LP_SUPPLY_ON;
  assign is_rd = spi_valid_in && spi_word_in == lpws_pkg::CMD_READ_CODE;
  assign is_ref = spi_valid_in && spi_word_in[15:8] == lpws_pkg::CMD_REFRESH;
  assign ref_ok = is_ref && spi_word_in[7:0] == ~random_code_out;
  assign is_wake = spi_valid_in && spi_word_in == lpws_pkg::CMD_WAKE;
  assign is_per = spi_valid_in && spi_word_in[15:8] == lpws_pkg::CMD_PERIOD &&
                  mode_in == lpws_pkg::M_NORMAL;
  assign period_end = us_tick && ci_cnt >= cint_period(cint_code) - 19'h1;
  always_comb begin
    next_ci_state = ci_state;
    next_ci_cnt = ci_cnt;
    next_int = 1'b0;
    next_rst_req = 1'b0;
    next_nrq = 1'b0;
    next_fail = (mode_in == lpws_pkg::M_NORMAL) ? 1'b0 : cint_fail;
    next_lfsr = {lfsr[6:0], 1'b0} ^ (lfsr[7] ? lpws_pkg::LFSR_TAPS : 8'h00);
    next_code = random_code_out;
    next_cint_code = cint_code;
    if (is_per) begin
      next_cint_code = (spi_word_in[7:0] > {4'h0, lpws_pkg::CINT_MAX_CODE}) ?
                       lpws_pkg::CINT_MAX_CODE : spi_word_in[3:0];
    end
    next_resp = spi_valid_in ? 16'h0000 : spi_resp_out;
    if (is_rd) next_resp = {8'h00, random_code_out};
    case (ci_state)
      CI_OFF: begin
        if (ci_run) begin
          next_ci_state = CI_FIRST;
          next_ci_cnt = '0;
        end
      end
      CI_FAIL: begin
        next_nrq = 1'b1;
        next_ci_state = CI_OFF;
      end
      default: begin
        if (us_tick) next_ci_cnt = ci_cnt + 19'h1;
        if (is_wake) begin
          next_nrq = 1'b1;
          next_ci_state = CI_OFF;
        end else if (!ci_run) begin
          next_ci_state = CI_OFF;
        end else if (is_ref && !ref_ok &&
                     (ci_state == CI_WAIT_RD || ci_state == CI_WAIT_REF)) begin
          next_rst_req = 1'b1;
          next_fail = 1'b1;
          next_ci_state = CI_FAIL;
        end else if (is_rd && ci_state == CI_WAIT_RD) begin
          next_ci_state = CI_WAIT_REF;
        end else if (ref_ok && ci_state == CI_WAIT_REF) begin
          next_ci_state = CI_ACKED;
          next_code = lfsr;
        end else if (period_end) begin
          next_ci_cnt = '0;
          if (ci_state == CI_FIRST || ci_state == CI_ACKED) begin
            next_int = 1'b1;
            next_ci_state = CI_WAIT_RD;
          end else begin
            next_rst_req = 1'b1;
            next_fail = 1'b1;
            next_ci_state = CI_FAIL;
          end
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ci_state <= CI_OFF;
      ci_cnt <= '0;
      cint_code <= lpws_pkg::CINT_MAX_CODE;
      lfsr <= lpws_pkg::LFSR_SEED;
      random_code_out <= lpws_pkg::CODE_RESET;
      spi_resp_out <= 16'h0000;
      cint_fail <= 1'b0;
      int_pulse_out <= 1'b0;
      reset_req_out <= 1'b0;
      normal_req_out <= 1'b0;
    end else begin
      ci_state <= next_ci_state;
      ci_cnt <= next_ci_cnt;
      cint_code <= next_cint_code;
      lfsr <= next_lfsr;
      random_code_out <= next_code;
      spi_resp_out <= next_resp;
      cint_fail <= next_fail;
      int_pulse_out <= next_int;
      reset_req_out <= next_rst_req;
      normal_req_out <= next_nrq;
    end
  end

  // ==========================================
  // Function gating per state
  logic n_main, n_lim, n_vcan, n_aux, n_can, n_canw, n_lin, n_linw, n_iow;
  logic n_io0h, n_io0l, n_io1h, n_io1l;
  always_comb begin
    n_main = 1'b1;
    n_lim = 1'b0;
    n_vcan = 1'b0;
    n_aux = 1'b0;
    n_can = 1'b0;
    n_canw = 1'b0;
    n_lin = 1'b0;
    n_linw = 1'b0;
    n_iow = 1'b0;
    n_io0h = 1'b0;
    n_io0l = 1'b0;
    n_io1h = 1'b0;
    n_io1l = 1'b0;
    case (mode_in)
      lpws_pkg::M_POWER_DOWN: n_main = 1'b0;
      lpws_pkg::M_INIT, lpws_pkg::M_RESET, lpws_pkg::M_NORMAL_REQ: begin
        n_vcan = vcan_ctl;
        n_lim = cint_fail;
        n_io0h = io0h_mem;
        n_io1h = io1h_mem;
        n_io1l = io1l_mem;
      end
      lpws_pkg::M_NORMAL, lpws_pkg::M_FLASH: begin
        n_vcan = vcan_ctl;
        n_aux = aux_cfg_in && mode_in == lpws_pkg::M_NORMAL;
        n_can = can_cfg_in;
        n_lin = lin_cfg_in && mode_in == lpws_pkg::M_NORMAL;
        n_iow = io_wake_cfg_in;
        n_io0h = io0_hs_cfg_in;
        n_io0l = io0_ls_cfg_in;
        n_io1h = io1_hs_cfg_in;
        n_io1l = io1_ls_cfg_in;
      end
      lpws_pkg::M_LP_SUPPLY_OFF, lpws_pkg::M_LP_SUPPLY_ON: begin
        n_main = mode_in == lpws_pkg::M_LP_SUPPLY_ON;
        n_lim = n_main;
        n_canw = can_wake_cfg_in;
        n_linw = lin_wake_cfg_in;
        n_iow = io_wake_cfg_in;
        n_io0h = io0h_mem && (!cs_active || cs_state == CS_ON);
        n_io0l = io0l_mem && (!cs_active || cs_state == CS_ON);
        n_io1h = io1h_mem;
        n_io1l = io1l_mem;
      end
      lpws_pkg::M_SAFE: begin
        n_main = !safe_case_b_in;
        n_vcan = !safe_case_b_in && vcan_ctl;
        n_canw = 1'b1;
        n_linw = 1'b1;
        n_iow = 1'b1;
      end
      default: ;
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      {main_regulator_on_out, main_regulator_limited_out, vcan_on_out, aux_on_out} <= 4'h0;
      {can_on_out, can_wake_en_out, lin_on_out, lin_wake_en_out, io_wake_en_out} <= 5'h00;
      {io0_hs_out, io0_ls_out, io1_hs_out, io1_ls_out} <= 4'h0;
    end else begin
      {main_regulator_on_out, main_regulator_limited_out, vcan_on_out, aux_on_out} <=
        {n_main, n_lim, n_vcan, n_aux};
      {can_on_out, can_wake_en_out, lin_on_out, lin_wake_en_out, io_wake_en_out} <=
        {n_can, n_canw, n_lin, n_linw, n_iow};
      {io0_hs_out, io0_ls_out, io1_hs_out, io1_ls_out} <= {n_io0h, n_io0l, n_io1h, n_io1l};
    end
  end

  // ==========================================
  // Checks
  sequence normal_hs_to_reset;
    mode_in == lpws_pkg::M_NORMAL && io0_hs_cfg_in ##1 mode_in == lpws_pkg::M_RESET;
  endsequence
  sequence bad_refresh;
    is_ref && !ref_ok && ci_run && (ci_state == CI_WAIT_RD || ci_state == CI_WAIT_REF);
  endsequence
  hs_keep_a: assert property (normal_hs_to_reset |=> io0_hs_out) else $error("hs lost");
  ls_off_a: assert property (mode_in == lpws_pkg::M_RESET |=> !io0_ls_out)
    else $error("io0 ls on in reset");
  ls1_keep_a: assert property (mode_in == lpws_pkg::M_NORMAL && io1_ls_cfg_in
    ##1 (mode_in == lpws_pkg::M_INIT || mode_in == lpws_pkg::M_RESET)
    |=> io1_ls_out) else $error("io1 ls lost");
  safe_wake_a: assert property (mode_in == lpws_pkg::M_SAFE |=> can_wake_en_out &&
    lin_wake_en_out && !can_on_out && !lin_on_out) else $error("safe gating");
  wake_sense_a: assert property (wake_out |-> $past(cs_state == CS_ON && |dg_hit))
    else $error("wake without sense");
  int_lp_on_a: assert property (int_pulse_out |-> $past(ci_run) && $past(ci_state) != CI_WAIT_REF)
    else $error("stray int");
  bad_ack_a: assert property (bad_refresh |=> reset_req_out ##1 normal_req_out && ci_state == CI_OFF)
    else $error("bad ack kept");
  first_free_a: assert property (ci_state == CI_FIRST |=> !reset_req_out)
    else $error("ack needed early");
  rd_code_a: assert property (is_rd |=> spi_resp_out == {8'h00, $past(random_code_out)})
    else $error("code answer");
  wake_cmd_a: assert property (is_wake && ci_state != CI_OFF && ci_state != CI_FAIL
    |=> normal_req_out ##1 !normal_req_out) else $error("wake cmd");
endmodule

// ==== design/lpws_pkg.sv ====
package lpws_pkg;
  // ==========================================
  // Operating states
  typedef enum logic [3:0] {
    M_POWER_DOWN, M_INIT_RESET, M_INIT, M_RESET, M_NORMAL_REQ, M_NORMAL,
    M_LP_SUPPLY_OFF, M_LP_SUPPLY_ON, M_SAFE, M_FLASH
  } lpws_mode_e;

  // ==========================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int US_CYC = CLK_HZ / 1_000_000;
  localparam int DEGLITCH_US = 30;
  localparam int DEGLITCH_CYC = DEGLITCH_US * US_CYC;
  localparam int DGW = 11;
  // 3 ms up to 512 ms
  localparam logic [18:0] CS_PERIOD_US [8] = '{19'h00BB8, 19'h01770, 19'h02EE0,
    19'h05DC0, 19'h0BB80, 19'h17700, 19'h2EE00, 19'h7D000};
  // 200 us, 400 us, 800 us, 1.6 ms
  localparam logic [18:0] SENSE_ON_US [4] = '{19'h000C8, 19'h00190, 19'h00320, 19'h00640};
  localparam logic [18:0] CINT_MAX_US = 19'h7D000;
  localparam logic [3:0] CINT_MAX_CODE = 4'hE;

  // ==========================================
  // Commands
  localparam logic [7:0] CMD_PERIOD = 8'h56;
  localparam logic [7:0] CMD_REFRESH = 8'h5A;
  localparam logic [15:0] CMD_READ_CODE = 16'h1B00;
  localparam logic [15:0] CMD_WAKE = 16'h5C10;

  // ==========================================
  // Reset values, LFSR taps and strap count points
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;
  localparam logic [7:0] CODE_RESET = 8'h3C;
  localparam logic [1:0] STRAP_LOAD = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;
endpackage

// ==== sim/lpws_host_model.sv ====
module lpws_host_model (
  input wire logic clk_in,
  input wire logic int_pulse_in,
  input wire logic [15:0] resp_in,
  input wire logic drive_in,
  input wire logic ack_en_in,
  input wire logic ack_bad_in,
  input wire logic [15:0] ack_delay_in,
  input wire logic contact_in,
  input wire logic glitch_in,
  output logic spi_valid_out,
  output logic [15:0] spi_word_out,
  output logic [2:0] sense_pin_out,
  output logic [7:0] last_code_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drive_q;
  logic [1:0] glitch_cnt;

  initial begin
    spi_valid_out = 1'h0;
    spi_word_out = 16'h0000;
    last_code_out = 8'h00;
    drive_q = 1'h0;
    glitch_cnt = 2'h0;
  end

  // ==========================================
  // Word transfer: released word shows its inverse
  task automatic send(input logic [15:0] w);
    spi_word_out = w;
    spi_valid_out = 1'h1;
    @(posedge clk_in);
    #2;
    spi_valid_out = 1'h0;
    spi_word_out = ~w;
  endtask

  // ==========================================
  // Contact switches: closed one on pin three, short bounce on pin one
  assign sense_pin_out = (contact_in && drive_in) ? 3'h4 :
    ((glitch_cnt != 2'h0) ? 3'h1 : 3'h0);
  always @(negedge clk_in) begin
    drive_q <= drive_in;
    if (glitch_in && drive_in && !drive_q) begin
      glitch_cnt <= 2'h2;
    end else if (glitch_cnt != 2'h0) begin
      glitch_cnt <= glitch_cnt - 2'h1;
    end
  end

  // ==========================================
  // Interrupt acknowledge: read code, then return it inverted
  always begin
    @(posedge clk_in);
    #2;
    if (int_pulse_in === 1'h1 && ack_en_in) begin
      repeat (ack_delay_in) begin
        @(posedge clk_in);
        #2;
      end
      send(16'h1B00);
      last_code_out = resp_in[7:0];
      @(posedge clk_in);
      #2;
      send({8'h5A, ack_bad_in ? last_code_out : ~last_code_out});
    end
  end
endmodule

// ==== sim/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

  typedef struct {lpws_pkg::lpws_mode_e m; logic b; logic [6:0] e;} lpws_row_s;
  localparam int UDIV = 1;
  localparam int CINT_P = (lpws_pkg::CINT_MAX_US >> (lpws_pkg::CINT_MAX_CODE - 4'h5)) * UDIV;
  lpws_pkg::lpws_mode_e mode_in;
  lpws_pkg::lpws_mode_e hold_m[3] = '{lpws_pkg::M_RESET, lpws_pkg::M_INIT,
    lpws_pkg::M_NORMAL_REQ};
  lpws_row_s rows[10] = '{
    '{lpws_pkg::M_NORMAL, 1'h0, 7'h75}, '{lpws_pkg::M_INIT, 1'h0, 7'h40},
    '{lpws_pkg::M_RESET, 1'h0, 7'h40}, '{lpws_pkg::M_NORMAL_REQ, 1'h0, 7'h40},
    '{lpws_pkg::M_LP_SUPPLY_OFF, 1'h0, 7'h0B}, '{lpws_pkg::M_LP_SUPPLY_ON, 1'h0, 7'h4B},
    '{lpws_pkg::M_SAFE, 1'h0, 7'h4B}, '{lpws_pkg::M_SAFE, 1'h1, 7'h0B},
    '{lpws_pkg::M_FLASH, 1'h0, 7'h51}, '{lpws_pkg::M_POWER_DOWN, 1'h0, 7'h00}};
  logic core_clk_in, rst_in, debug_select_pin_in, safe_case_b_in, vcan_set_in, vcan_clr_in;
  logic aux_cfg_in, can_cfg_in, can_wake_cfg_in, lin_cfg_in, lin_wake_cfg_in, io_wake_cfg_in;
  logic io0_hs_cfg_in, io0_ls_cfg_in, io1_hs_cfg_in, io1_ls_cfg_in, cs_en_in, cint_en_in;
  logic spi_valid_in, main_regulator_on_out, main_regulator_limited_out, vcan_on_out;
  logic aux_on_out, can_on_out, can_wake_en_out, lin_on_out, lin_wake_en_out, io_wake_en_out;
  logic io0_hs_out, io0_ls_out, io1_hs_out, io1_ls_out, wake_out, int_pulse_out;
  logic reset_req_out, normal_req_out, ack_en, ack_bad, contact, glitch;
  logic [2:0] cs_period_sel_in, sense_pin_in;
  logic [1:0] sense_on_sel_in;
  logic [15:0] spi_word_in, spi_resp_out, ack_delay;
  logic [7:0] random_code_out, code_seen;
  int n_errors, n_compared, n_int, n_rst, d, w, k;

  lpws_supervisor #(.US_DIV(UDIV), .DG_CYC(3)) u_lpws_supervisor (.core_clk_in, .rst_in,
    .mode_in, .debug_select_pin_in, .safe_case_b_in, .vcan_set_in, .vcan_clr_in, .aux_cfg_in,
    .can_cfg_in, .can_wake_cfg_in, .lin_cfg_in, .lin_wake_cfg_in, .io_wake_cfg_in,
    .io0_hs_cfg_in, .io0_ls_cfg_in, .io1_hs_cfg_in, .io1_ls_cfg_in, .cs_en_in,
    .cs_period_sel_in, .sense_on_sel_in, .cint_en_in, .sense_pin_in, .spi_valid_in,
    .spi_word_in, .main_regulator_on_out, .main_regulator_limited_out, .vcan_on_out,
    .aux_on_out, .can_on_out, .can_wake_en_out, .lin_on_out, .lin_wake_en_out,
    .io_wake_en_out, .io0_hs_out, .io0_ls_out, .io1_hs_out, .io1_ls_out, .wake_out,
    .int_pulse_out, .reset_req_out, .normal_req_out, .spi_resp_out, .random_code_out);
  lpws_host_model u_lpws_host_model (.clk_in(core_clk_in), .int_pulse_in(int_pulse_out),
    .resp_in(spi_resp_out), .drive_in(io0_hs_out | io0_ls_out), .ack_en_in(ack_en),
    .ack_bad_in(ack_bad), .ack_delay_in(ack_delay), .contact_in(contact), .glitch_in(glitch),
    .spi_valid_out(spi_valid_in), .spi_word_out(spi_word_in), .sense_pin_out(sense_pin_in),
    .last_code_out(code_seen));

  // ==========================================
  // Clock, event counters and helpers
  initial begin
    core_clk_in = 1'h0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    #1;
    if (int_pulse_out === 1'h1) n_int++;
    if (reset_req_out === 1'h1) n_rst++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #2;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return int_pulse_out;
      1: return reset_req_out;
      2: return normal_req_out;
      3: return io0_hs_out | io0_ls_out;
      default: return wake_out;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim, output int c);
    c = 0;
    while (pick(s) !== 1'h1 && c < lim) begin
      tick(1);
      c++;
    end
    if (c >= lim) begin
      n_errors++;
      $display("[ERR] wait %0d exp event got timeout", s);
      stop_test();
    end
  endtask
  task automatic near(input string nm, input int e, input int g, input int tol);
    n_compared++;
    if (g < e - tol || g > e + tol) begin
      n_errors++;
      $display("[ERR] %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rst_in, debug_select_pin_in, ack_en} = 3'h7;
    {safe_case_b_in, vcan_set_in, vcan_clr_in, io0_hs_cfg_in, io0_ls_cfg_in} = 5'h00;
    {io1_hs_cfg_in, io1_ls_cfg_in, cs_en_in, cint_en_in, ack_bad, contact, glitch} = 7'h00;
    {aux_cfg_in, can_cfg_in, can_wake_cfg_in, lin_cfg_in, lin_wake_cfg_in, io_wake_cfg_in} = 6'h3F;
    {cs_period_sel_in, sense_on_sel_in, ack_delay} = 21'h000000;
    mode_in = lpws_pkg::M_NORMAL;
    tick(19);
    `CHK("reset code", lpws_pkg::CODE_RESET, random_code_out)
    `CHK("reset flags", 5'h00, {wake_out, int_pulse_out, reset_req_out, normal_req_out, vcan_on_out})
    tick(1);
    rst_in = 1'h0;
    tick(4);
    `CHK("vcan debug", 1'h1, vcan_on_out)
    vcan_clr_in = 1'h1;
    tick(1);
    vcan_clr_in = 1'h0;
    tick(2);
    `CHK("vcan off", 1'h0, vcan_on_out)
    vcan_set_in = 1'h1;
    tick(1);
    vcan_set_in = 1'h0;
    tick(2);
    `CHK("vcan on", 1'h1, vcan_on_out)
    for (k = 0; k < 10; k++) begin
      mode_in = rows[k].m;
      safe_case_b_in = rows[k].b;
      tick(2);
      `CHK("gating", rows[k].e, {main_regulator_on_out, aux_on_out, can_on_out, can_wake_en_out, lin_on_out, lin_wake_en_out, io_wake_en_out})
    end
    mode_in = lpws_pkg::M_NORMAL;
    {io0_hs_cfg_in, io0_ls_cfg_in, io1_hs_cfg_in, io1_ls_cfg_in} = 4'h9;
    tick(2);
    {io0_hs_cfg_in, io0_ls_cfg_in, io1_hs_cfg_in, io1_ls_cfg_in} = 4'h0;
    for (k = 0; k < 3; k++) begin
      mode_in = hold_m[k];
      tick(2);
      `CHK("hold high", 4'h9, {io0_hs_out, io0_ls_out, io1_hs_out, io1_ls_out})
    end
    mode_in = lpws_pkg::M_NORMAL;
    {io0_hs_cfg_in, io0_ls_cfg_in, io1_hs_cfg_in, io1_ls_cfg_in} = 4'h6;
    tick(2);
    mode_in = lpws_pkg::M_RESET;
    tick(2);
    `CHK("low side off", 4'h2, {io0_hs_out, io0_ls_out, io1_hs_out, io1_ls_out})
    mode_in = lpws_pkg::M_NORMAL;
    tick(2);
    `CHK("low side back", 4'h6, {io0_hs_out, io0_ls_out, io1_hs_out, io1_ls_out})
    // Contact sensing: high side with closed contact, low side with bounce
    for (k = 0; k < 2; k++) begin
      {io0_hs_cfg_in, io0_ls_cfg_in, io1_hs_cfg_in, io1_ls_cfg_in} = 4'h0;
      mode_in = lpws_pkg::M_INIT;
      sense_on_sel_in = k ? 2'h3 : 2'h0;
      tick(2);
      mode_in = lpws_pkg::M_NORMAL;
      {io0_hs_cfg_in, io0_ls_cfg_in} = k ? 2'h1 : 2'h2;
      cs_period_sel_in = 3'(k);
      {cs_en_in, cint_en_in, contact, glitch} = k ? 4'h9 : 4'hE;
      tick(2);
      n_int = 0;
      mode_in = k ? lpws_pkg::M_LP_SUPPLY_ON : lpws_pkg::M_LP_SUPPLY_OFF;
      tick(1);
      wait_for(3, 8000, d);
      near("sense period", lpws_pkg::CS_PERIOD_US[k] * UDIV, d, 4);
      `CHK("drive side", k ? 2'h1 : 2'h2, {io0_hs_out, io0_ls_out})
      if (k == 0) begin
        wait_for(4, 20, d);
        `CHK("contact wake", 1'h1, wake_out)
      end else begin
        w = 0;
        for (d = 0; pick(3) === 1'h1 && d < 3000; d++) begin
          if (wake_out === 1'h1) w++;
          tick(1);
        end
        near("sense on", lpws_pkg::SENSE_ON_US[3] * UDIV, d, 3);
        `CHK("bounce wake", 0, w)
      end
      `CHK("no int", 0, n_int)
      {cs_en_in, cint_en_in, contact, glitch} = 4'h0;
      mode_in = lpws_pkg::M_NORMAL;
      tick(2);
    end
    // Periodic interrupt with early and late acknowledge
    cint_en_in = 1'h1;
    u_lpws_host_model.send(16'h5605);
    mode_in = lpws_pkg::M_RESET;
    tick(1);
    u_lpws_host_model.send(16'h5600);
    n_rst = 0;
    mode_in = lpws_pkg::M_LP_SUPPLY_ON;
    wait_for(0, 1200, d);
    near("first int", CINT_P, d, 4);
    tick(8);
    `CHK("new code", 1'h1, random_code_out !== code_seen)
    ack_delay = 16'h0384;
    wait_for(0, 1200, d);
    near("second int", CINT_P - 8, d, 4);
    tick(1);
    wait_for(0, 1200, d);
    near("third int", CINT_P - 1, d, 4);
    `CHK("acks taken", 0, n_rst)
    tick(950);
    u_lpws_host_model.send(16'h5C10);
    `CHK("wake command", 1'h1, normal_req_out)
    mode_in = lpws_pkg::M_NORMAL_REQ;
    n_int = 0;
    tick(1100);
    `CHK("int stopped", 0, n_int + n_rst)
    // Wrong and missing acknowledge
    mode_in = lpws_pkg::M_NORMAL;
    {ack_bad, ack_delay} = 17'h10000;
    tick(2);
    mode_in = lpws_pkg::M_LP_SUPPLY_ON;
    wait_for(0, 1200, d);
    wait_for(1, 12, d);
    `CHK("bad code reset", 1'h1, reset_req_out)
    tick(1);
    `CHK("bad code req", 1'h1, normal_req_out)
    mode_in = lpws_pkg::M_NORMAL_REQ;
    tick(2);
    `CHK("limited", 2'h3, {main_regulator_on_out, main_regulator_limited_out})
    mode_in = lpws_pkg::M_NORMAL;
    ack_en = 1'h0;
    tick(2);
    `CHK("limited off", 1'h0, main_regulator_limited_out)
    mode_in = lpws_pkg::M_LP_SUPPLY_ON;
    wait_for(0, 1200, d);
    wait_for(1, 1200, d);
    near("missing ack", CINT_P + 1, d, 3);
    tick(1);
    `CHK("missing ack req", 1'h1, normal_req_out)
    stop_test();
  end
endmodule
